/* File: design/dmem_pkg.sv */
// constants, address map and state layout of the sectored data memory
// assumes one 40 MHz clock and the CPU core as the only master
package dmem_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 9;
  localparam int NUM_SECTORS = 2;
  localparam int GP_PER_SECTOR = 128;
  localparam int GP_BYTES = 256;
  localparam int GP_AW = 8;
  localparam int BIT_W = 3;

  localparam logic [7:0] GP_BASE = 8'h80;
  localparam logic [7:0] SFR_LAST = 8'h7F;

  // sector 0 special-function map
  localparam logic [7:0] OFS_INDIRECT_PORT_SECTOR_ZERO = 8'h00;
  localparam logic [7:0] OFS_POINTER_SECTOR_ZERO = 8'h01;
  localparam logic [7:0] OFS_INDIRECT_PORT_A = 8'h02;
  localparam logic [7:0] OFS_POINTER_A_LOW = 8'h03;
  localparam logic [7:0] OFS_POINTER_A_SECTOR = 8'h04;
  localparam logic [7:0] OFS_ACC = 8'h05;
  localparam logic [7:0] OFS_INDIRECT_PORT_B = 8'h06;
  localparam logic [7:0] OFS_POINTER_B_LOW = 8'h07;
  localparam logic [7:0] OFS_POINTER_B_SECTOR = 8'h08;
  localparam logic [7:0] OFS_LAST_SECTOR = 8'h09;

  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] SECTOR_ZERO = 8'h00;

  typedef struct packed {
    logic [7:0] ptr0_r;
    logic [7:0] pa_lo_r;
    logic [7:0] pa_sec_r;
    logic [7:0] pb_lo_r;
    logic [7:0] pb_sec_r;
    logic [7:0] acc_r;
    logic [7:0] last_sec_r;
    logic [7:0] rdata_r;
  } state_t;

endpackage

/* File: design/gp_mem_if.sv */
// port between the address resolver and the general-purpose byte store
// assumes the store answers reads combinationally in the same cycle
`timescale 1ns/1ps
interface gp_mem_if #(parameter int AW = 8, parameter int DW = 8);
  logic [AW-1:0] addr;
  logic we;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport resolver (output addr, output we, output wdata, input rdata);
  modport store (input addr, input we, input wdata, output rdata);
endinterface

/* File: design/gp_store.sv */
// general-purpose byte store held in flip-flops, one byte per index
// assumes the resolver drives one write per cycle at most
`timescale 1ns/1ps
module gp_store #(
  parameter int DEPTH = 256,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // access from the resolver
  gp_mem_if.store m
);
  import dmem_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][DW-1:0] mem_r;
  } store_t;

  store_t s_r;
  store_t s_nxt;

  initial begin
    if (DEPTH != (1 << $bits(m.addr)))
      $error("gp_store depth must match its address width");
  end

  assign m.rdata = s_r.mem_r[m.addr];

  always_comb begin
    s_nxt = s_r;
    if (m.we) begin
      s_nxt.mem_r[m.addr] = m.wdata;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

/* File: design/dmem_top.sv */
// sectored data memory: address resolution, pointers, accumulator and
// the general-purpose store of an 8-bit core
// assumes the core issues at most one memory request per cycle and that
// its strobes are single-cycle pulses synchronous to CLK
`timescale 1ns/1ps
module dmem_top #(
  parameter int SECTORS = dmem_pkg::NUM_SECTORS,
  parameter int GP_DEPTH = dmem_pkg::GP_BYTES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // memory request from the core
  input wire logic [dmem_pkg::ADDR_W-1:0] ADDR,
  input wire logic [dmem_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic WR_FROM_ACC,
  // bit manipulation on the addressed byte
  input wire logic BIT_SET,
  input wire logic BIT_CLR,
  input wire logic [dmem_pkg::BIT_W-1:0] BIT_SEL,
  // accumulator load
  input wire logic ACC_WR,
  input wire logic ACC_LD,
  input wire logic [dmem_pkg::DATA_W-1:0] ALU_Y,
  // answers
  output logic [dmem_pkg::DATA_W-1:0] RDATA,
  output logic [dmem_pkg::DATA_W-1:0] ACC,
  output logic [dmem_pkg::DATA_W-1:0] LAST_SECTOR
);
  import dmem_pkg::*;

  state_t s_r;
  state_t s_nxt;

  gp_mem_if #(.AW(GP_AW), .DW(DATA_W)) gp ();

  gp_store #(.DEPTH(GP_DEPTH), .DW(DATA_W)) u_store (
    .CLK(CLK),
    .RSTN(RSTN),
    .m(gp.store)
  );

  initial begin
    if (SECTORS < 1 || SECTORS > 2)
      $error("dmem_top serves one or two sectors only");
    if (GP_DEPTH != SECTORS * GP_PER_SECTOR)
      $error("dmem_top general-purpose depth must be 128 bytes per sector");
  end

  // resolved target of the current request
  logic [7:0] eff_sec;
  logic [7:0] eff_lo;
  logic sec_ok;
  logic is_gp;
  logic [7:0] rd_val;
  logic [7:0] wr_val;
  logic [7:0] bit_mask;
  logic do_wr;
  logic gp_we;

  // target resolution
  always_comb begin
    eff_sec = {7'h00, ADDR[8]};
    eff_lo = ADDR[7:0];
    if (!ADDR[8]) begin
      unique case (ADDR[7:0])
        OFS_INDIRECT_PORT_SECTOR_ZERO: begin
          eff_sec = SECTOR_ZERO;
          eff_lo = s_r.ptr0_r;
        end
        OFS_INDIRECT_PORT_A: begin
          eff_sec = s_r.pa_sec_r;
          eff_lo = s_r.pa_lo_r;
        end
        OFS_INDIRECT_PORT_B: begin
          eff_sec = s_r.pb_sec_r;
          eff_lo = s_r.pb_lo_r;
        end
        default: begin
          eff_sec = SECTOR_ZERO;
          eff_lo = ADDR[7:0];
        end
      endcase
    end
    // sectors beyond the implemented ones never reach storage
    sec_ok = (eff_sec < 8'(SECTORS));
    is_gp = eff_lo >= GP_BASE;
  end

  // read value of the resolved target
  always_comb begin
    rd_val = ZERO_BYTE;
    if (sec_ok) begin
      if (is_gp) begin
        rd_val = gp.rdata;
      end else if (eff_sec == SECTOR_ZERO) begin
        unique case (eff_lo)
          OFS_POINTER_SECTOR_ZERO: rd_val = s_r.ptr0_r;
          OFS_POINTER_A_LOW: rd_val = s_r.pa_lo_r;
          OFS_POINTER_A_SECTOR: rd_val = s_r.pa_sec_r;
          OFS_POINTER_B_LOW: rd_val = s_r.pb_lo_r;
          OFS_POINTER_B_SECTOR: rd_val = s_r.pb_sec_r;
          OFS_ACC: rd_val = s_r.acc_r;
          OFS_LAST_SECTOR: rd_val = s_r.last_sec_r;
          // a pointer aimed at a port lands here: no nested redirection
          OFS_INDIRECT_PORT_SECTOR_ZERO: rd_val = ZERO_BYTE;
          OFS_INDIRECT_PORT_A: rd_val = ZERO_BYTE;
          OFS_INDIRECT_PORT_B: rd_val = ZERO_BYTE;
          default: rd_val = ZERO_BYTE;
        endcase
      end else begin
        rd_val = ZERO_BYTE;
      end
    end
  end

  // write value: the written byte comes from WDATA or the accumulator, or is the
  // target's own read data with one bit set or cleared, never another location's
  always_comb begin
    bit_mask = 8'h01 << BIT_SEL;
    do_wr = WR | BIT_SET | BIT_CLR;
    if (WR) begin
      wr_val = WR_FROM_ACC ? s_r.acc_r : WDATA;
    end else if (BIT_SET) begin
      wr_val = rd_val | bit_mask;
    end else if (BIT_CLR) begin
      wr_val = rd_val & ~bit_mask;
    end else begin
      wr_val = ZERO_BYTE;
    end
    gp_we = do_wr && sec_ok && is_gp;
  end

  assign gp.addr = {eff_sec[0], eff_lo[6:0]};
  assign gp.we = gp_we;
  assign gp.wdata = wr_val;

  // register update
  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata_r = RD ? rd_val : ZERO_BYTE;
    if (RD || do_wr) begin
      s_nxt.last_sec_r = eff_sec;
    end
    if (do_wr && sec_ok && !is_gp && eff_sec == SECTOR_ZERO) begin
      unique case (eff_lo)
        OFS_POINTER_SECTOR_ZERO: s_nxt.ptr0_r = wr_val;
        OFS_POINTER_A_LOW: s_nxt.pa_lo_r = wr_val;
        OFS_POINTER_A_SECTOR: s_nxt.pa_sec_r = wr_val;
        OFS_POINTER_B_LOW: s_nxt.pb_lo_r = wr_val;
        OFS_POINTER_B_SECTOR: s_nxt.pb_sec_r = wr_val;
        OFS_ACC: s_nxt.acc_r = wr_val;
        // protected: written data is dropped; it still takes the sector of this access
        OFS_LAST_SECTOR: s_nxt.last_sec_r = s_nxt.last_sec_r;
        default: s_nxt.ptr0_r = s_nxt.ptr0_r;
      endcase
    end
    if (ACC_LD && RD) begin
      s_nxt.acc_r = rd_val;
    end
    // an ALU result outranks any other load of the accumulator
    if (ACC_WR) begin
      s_nxt.acc_r = ALU_Y;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      s_r.ptr0_r <= RST_BYTE;
      s_r.pa_lo_r <= RST_BYTE;
      s_r.pa_sec_r <= RST_BYTE;
      s_r.pb_lo_r <= RST_BYTE;
      s_r.pb_sec_r <= RST_BYTE;
      s_r.acc_r <= RST_BYTE;
      s_r.last_sec_r <= RST_BYTE;
      s_r.rdata_r <= RST_BYTE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign RDATA = s_r.rdata_r;
  assign ACC = s_r.acc_r;
  assign LAST_SECTOR = s_r.last_sec_r;
endmodule

/* File: tb/dmem_asserts.sv */
// port-level checks for the sectored data memory
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/1ps
module dmem_asserts (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // core request
  input wire logic [8:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic WR_FROM_ACC,
  input wire logic BIT_SET,
  input wire logic BIT_CLR,
  input wire logic ACC_WR,
  input wire logic ACC_LD,
  input wire logic [7:0] ALU_Y,
  // answers
  input wire logic [7:0] RDATA,
  input wire logic [7:0] ACC,
  input wire logic [7:0] LAST_SECTOR
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  rdata_idle_a: assert property (!$past(RD) |-> RDATA == 8'h00) else $error("read data not idle");
  acc_alu_a: assert property (ACC_WR |=> ACC == $past(ALU_Y)) else $error("alu result lost");
  acc_load_a: assert property (RD && ACC_LD && !ACC_WR |=> ACC == RDATA) else $error("acc load wrong");
  acc_hold_a: assert property (!(ACC_WR || ACC_LD || WR || BIT_SET || BIT_CLR) |=> $stable(ACC))
    else $error("acc moved");
  // reset edges may clear the sector byte, so they are excused
  sector_cause_a: assert property ($changed(LAST_SECTOR) && $past(RSTN) |-> $past(RD || WR || BIT_SET || BIT_CLR))
    else $error("sector changed alone");
  direct_sector_a: assert property ((RD || WR) && (ADDR[8] || !(ADDR[7:0] inside {8'h00, 8'h02, 8'h06}))
    |=> LAST_SECTOR == 8'($past(ADDR) >> 8)) else $error("direct sector wrong");
  sec1_sfr_a: assert property (RD && ADDR[8] && !ADDR[7] |=> RDATA == 8'h00) else $error("sector 1 sfr not zero");
  last_read_a: assert property (RD && ADDR == 9'h009 |=> RDATA == $past(LAST_SECTOR)) else $error("sector read");
  gp_write_a: assert property (WR && !WR_FROM_ACC && ADDR[7] ##1 RD && ADDR == $past(ADDR)
    |=> RDATA == $past(WDATA, 2)) else $error("byte not stored");
endmodule
bind dmem_top dmem_asserts checker_i (.CLK(CLK), .RSTN(RSTN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
  .WR_FROM_ACC(WR_FROM_ACC), .BIT_SET(BIT_SET), .BIT_CLR(BIT_CLR), .ACC_WR(ACC_WR), .ACC_LD(ACC_LD),
  .ALU_Y(ALU_Y), .RDATA(RDATA), .ACC(ACC), .LAST_SECTOR(LAST_SECTOR));

/* File: tb/alu_model.sv */
// core-side arithmetic unit whose results head for the accumulator
// assumes a combinational path settled well within one cycle
`timescale 1ns/1ps
module alu_model (
  // operands
  input wire logic [7:0] ACC,
  input wire logic [7:0] OPND,
  input wire logic [1:0] OP,
  // result
  output logic [7:0] ALU_Y
);
  // no path to memory here: results only reach it through the accumulator
  always_comb begin
    case (OP)
      2'h0: ALU_Y = ACC + OPND;
      2'h1: ALU_Y = ACC - OPND;
      2'h2: ALU_Y = ACC & OPND;
      default: ALU_Y = ACC ^ OPND;
    endcase
  end
endmodule

/* File: tb/sectored_data_memory_addressing_tb_top.sv */
// random core traffic on the data memory, checked against a queue-free model
// assumes the design files and the arithmetic partner are compiled first
`timescale 1ns/1ps
module sectored_data_memory_addressing_tb_top;
  logic clk = 0, rstn = 0, wr = 0, rd = 0, wfa = 0, bs = 0, bc = 0, aw = 0, ld = 0;
  logic [8:0] a = 9'h000, na;
  logic [7:0] wd = 8'h00, opnd = 8'h00, aluy, rdata, acc, lsec;
  logic [2:0] sel = 3'h0;
  logic [1:0] op = 2'h0;
  int m[512], last, erd, miscompares, n_compared, seed = 32'h224d, r, d, k, oa;
  always #12.5 clk = ~clk;
  alu_model partner (.ACC(acc), .OPND(opnd), .OP(op), .ALU_Y(aluy));
  dmem_top DUT (.CLK(clk), .RSTN(rstn), .ADDR(a), .WDATA(wd), .WR(wr), .RD(rd), .WR_FROM_ACC(wfa),
    .BIT_SET(bs), .BIT_CLR(bc), .BIT_SEL(sel), .ACC_WR(aw), .ACC_LD(ld), .ALU_Y(aluy),
    .RDATA(rdata), .ACC(acc), .LAST_SECTOR(lsec));
  function automatic bit wok(int x);
    return x < 512 && (x[7] || x inside {1, 3, 4, 5, 7, 8});
  endfunction
  function automatic int rdv(int x);
    return x == 9 ? last : wok(x) ? m[x] : 0;
  endfunction
  // ports resolve through pointers; a pointer naming a port lands on a zero byte
  function automatic int res(int x);
    return x == 0 ? m[1] : x == 2 ? m[4] * 256 + m[3] : x == 6 ? m[8] * 256 + m[7] : x;
  endfunction
  function automatic int alu(int x);
    case (op)
      2'h0: return (x + opnd) & 255;
      2'h1: return (x - opnd) & 255;
      2'h2: return x & opnd;
      default: return x ^ opnd;
    endcase
  endfunction
  task automatic step();
    erd = 0;
    if (!rstn) begin
      m = '{default: 0};
      last = 0;
    end else begin
      // the arithmetic unit sees the accumulator as it stood before this edge
      oa = m[5];
      r = res(a);
      d = rdv(r);
      if (rd) erd = d;
      if (rd || wr || bs || bc) last = r >> 8;
      if (wr) d = wfa ? m[5] : wd;
      else if (bs) d = d | (1 << sel);
      else if (bc) d = d & ~(1 << sel) & 255;
      if ((wr || bs || bc) && wok(r)) m[r] = d;
      if (rd && ld) m[5] = erd;
      if (aw) m[5] = alu(oa);
    end
  endtask
  task automatic chk(string s, logic [7:0] seen, int e);
    n_compared++;
    if (seen !== e[7:0]) begin
      miscompares++;
      $display("MISMATCH %s expected %0h seen %0h", s, e[7:0], seen);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (5) @(posedge clk) step();
    rstn <= 1'b1;
    for (int i = 0; i < 2000; i++) begin
      @(negedge clk);
      chk("RDATA", rdata, erd);
      chk("ACC", acc, m[5]);
      chk("LAST_SECTOR", lsec, last);
      @(posedge clk);
      step();
      k = {$random(seed)} % 4;
      // low sector-zero offsets hit ports, pointers and holes; repeats give write-then-read
      na = k == 0 ? {5'h00, 4'($random(seed))} : k == 1 ? 9'($random(seed)) : a;
      a <= na;
      k = {$random(seed)} % 5;
      rd <= k == 0;
      wr <= k == 1;
      bs <= k == 2;
      bc <= k == 3;
      // sector bytes mostly name sectors 0 and 1, sometimes the missing sector 2
      wd <= (na inside {9'h004, 9'h008}) ? 8'({$random(seed)} % 3) : 8'($random(seed));
      aw <= {$random(seed)} % 4 == 0;
      ld <= 1'($random(seed));
      wfa <= 1'($random(seed));
      sel <= 3'($random(seed));
      op <= 2'($random(seed));
      opnd <= 8'($random(seed));
      rstn <= i != 1000;
    end
    stop_test();
  end
endmodule
